//--- hw/dmas_sfr_core.sv
// Summary of operation
// - Access to an indirect port goes to the location its pointer holds.
// - Indirect ports store nothing: targeted themselves they read 00H, writes do nothing.
// - First indirect port always reaches bank 0.
// - Second indirect port reaches the bank chosen by the bank selector.
// - Direct data memory addressing always reaches bank 0.
// - Special register region is the same in every bank.
// - Reset clears bank selection, except watchdog reset in idle or sleep.
// - Two-bank variant: selector bit 0 only, upper bits read zero.
// - Four-bank variant: selector bits 1..0, upper bits read zero.
// - Pointers are ordinary read, write and modify registers.
// - Smallest variant has only the first indirect port and pointer.
// - Writing the program counter low byte jumps within the current page.
// - A program counter low byte write costs one extra dummy cycle.
// - Table read: high byte to latch, low byte to named destination.
// - ALU results land in the accumulator; no memory-to-memory path.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dmas_regs.svh"

module dmas_sfr_core #(
  parameter int NUM_BANKS = 4
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wdt_idle_rst,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // ALU result into the accumulator
  input  wire logic        alu_valid,
  input  wire logic [7:0]  alu_result,
  output logic      [7:0]  acc_out,
  // Program memory table fetch
  output logic             prog_req,
  output logic      [15:0] prog_addr,
  input  wire logic [15:0] prog_rdata,
  // Program counter low byte jump
  output logic             pc_jump,
  output logic      [7:0]  pc_jump_low
);

  localparam bit HAS_SECOND = (NUM_BANKS > 1);
  localparam bit HAS_TABLE_POINTER_HIGH   = (NUM_BANKS == 4);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  dmas_pkg::dmas_state_t  state_reg;
  dmas_pkg::dmas_target_t tgt;
  logic        aw_have_reg;
  logic [11:0] aw_addr_reg;
  logic        w_have_reg;
  logic [7:0]  w_data_reg;
  logic        w_en_reg;
  logic [11:0] ar_addr_reg;
  logic [7:0]  ptr_first_reg;
  logic [7:0]  ptr_second_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  pcl_reg;
  logic [7:0]  table_pointer_low_reg;
  logic [7:0]  table_pointer_high_reg;
  logic [7:0]  table_high_byte_latch_reg;
  logic [7:0]  tbl_dest_reg;
  logic [1:0]  bank;
  logic [7:0]  bank_rdata;
  logic [7:0]  ram_rdata;
  logic [11:0] cur_addr;
  logic [7:0]  cur_daddr;
  logic        cur_is_data;
  logic        do_wr;
  logic [7:0]  wr_byte;
  logic        sfr_wr;
  logic [7:0]  rd_byte;

  // --------------------------------------------------------------------------
  // Address resolution
  // --------------------------------------------------------------------------
  always_comb begin
    cur_addr = (state_reg == dmas_pkg::ST_REXEC) ? ar_addr_reg : aw_addr_reg;
    cur_is_data = (cur_addr[11:10] == 2'h0) && (cur_addr[1:0] == 2'h0);
    cur_daddr = (state_reg == dmas_pkg::ST_TBL2) ? tbl_dest_reg : cur_addr[9:2];
  end

  always_comb begin
    tgt.bank = `DMAS_BANK0;
    tgt.addr = cur_daddr;
    if (cur_daddr == `DMAS_SFR_IND_FIRST) begin
      tgt.addr = ptr_first_reg;
    end else if (HAS_SECOND && cur_daddr == `DMAS_SFR_IND_SECOND) begin
      tgt.addr = ptr_second_reg;
      tgt.bank = bank;
    end
    // The special region ignores the bank, so every bank sees one copy.
    tgt.ram = tgt.addr[`DMAS_GEN_BIT];
    tgt.nop = (tgt.addr == `DMAS_SFR_IND_FIRST) ||
              (HAS_SECOND && tgt.addr == `DMAS_SFR_IND_SECOND);
  end

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  always_comb begin
    do_wr = ((state_reg == dmas_pkg::ST_WEXEC) && w_en_reg && cur_is_data) ||
            (state_reg == dmas_pkg::ST_TBL2);
    wr_byte = (state_reg == dmas_pkg::ST_TBL2) ? prog_rdata[7:0] : w_data_reg;
    sfr_wr = do_wr && !tgt.nop && !tgt.ram;
  end

  dmas_bank_sel #(
    .NUM_BANKS    (NUM_BANKS)
  ) u_bank_sel (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .wdt_idle_rst (wdt_idle_rst),
    .wr_en        (sfr_wr && HAS_SECOND && tgt.addr == `DMAS_SFR_BANK_SEL),
    .wdata        (wr_byte),
    .bank         (bank),
    .rdata        (bank_rdata)
  );

  dmas_data_ram #(
    .NUM_BANKS (NUM_BANKS)
  ) u_data_ram (
    .sys_clk   (sys_clk),
    .wr_en     (do_wr && !tgt.nop && tgt.ram),
    .bank      (tgt.bank),
    .addr      (tgt.addr[6:0]),
    .wdata     (wr_byte),
    .rdata     (ram_rdata)
  );

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always_comb begin
    rd_byte = `DMAS_ZERO_BYTE;
    if (tgt.nop) begin
      rd_byte = `DMAS_PORT_READ;
    end else if (tgt.ram) begin
      rd_byte = ram_rdata;
    end else begin
      unique case (tgt.addr)
        `DMAS_SFR_PTR_FIRST:  rd_byte = ptr_first_reg;
        `DMAS_SFR_PTR_SECOND: rd_byte = HAS_SECOND ? ptr_second_reg : `DMAS_ZERO_BYTE;
        `DMAS_SFR_BANK_SEL:   rd_byte = HAS_SECOND ? bank_rdata : `DMAS_ZERO_BYTE;
        `DMAS_SFR_ACC:        rd_byte = acc_reg;
        `DMAS_SFR_PCL:        rd_byte = pcl_reg;
        `DMAS_SFR_TABLE_POINTER_LOW:       rd_byte = table_pointer_low_reg;
        `DMAS_SFR_TABLE_HIGH_BYTE_LATCH:       rd_byte = table_high_byte_latch_reg;
        `DMAS_SFR_TABLE_POINTER_HIGH:       rd_byte = HAS_TABLE_POINTER_HIGH ? table_pointer_high_reg : `DMAS_ZERO_BYTE;
        default:              rd_byte = `DMAS_ZERO_BYTE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Special function registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_first_reg  <= `DMAS_ZERO_BYTE;
      ptr_second_reg <= `DMAS_ZERO_BYTE;
      table_pointer_low_reg       <= `DMAS_ZERO_BYTE;
      table_pointer_high_reg       <= `DMAS_ZERO_BYTE;
    end else if (sfr_wr) begin
      if (tgt.addr == `DMAS_SFR_PTR_FIRST) begin
        ptr_first_reg <= wr_byte;
      end
      if (HAS_SECOND && tgt.addr == `DMAS_SFR_PTR_SECOND) begin
        ptr_second_reg <= wr_byte;
      end
      if (tgt.addr == `DMAS_SFR_TABLE_POINTER_LOW) begin
        table_pointer_low_reg <= wr_byte;
      end
      if (HAS_TABLE_POINTER_HIGH && tgt.addr == `DMAS_SFR_TABLE_POINTER_HIGH) begin
        table_pointer_high_reg <= wr_byte;
      end
    end
  end

  // A bus write to the accumulator wins over an ALU result in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_reg <= `DMAS_ZERO_BYTE;
    end else if (sfr_wr && tgt.addr == `DMAS_SFR_ACC) begin
      acc_reg <= wr_byte;
    end else if (alu_valid) begin
      acc_reg <= alu_result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      table_high_byte_latch_reg <= `DMAS_ZERO_BYTE;
    end else if (state_reg == dmas_pkg::ST_TBL2) begin
      table_high_byte_latch_reg <= prog_rdata[15:8];
    end else if (sfr_wr && tgt.addr == `DMAS_SFR_TABLE_HIGH_BYTE_LATCH) begin
      table_high_byte_latch_reg <= wr_byte;
    end
  end

  // Only the low byte is loaded, so the jump stays inside the page.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pcl_reg     <= `DMAS_ZERO_BYTE;
      pc_jump     <= 1'b0;
      pc_jump_low <= `DMAS_ZERO_BYTE;
    end else begin
      pc_jump <= sfr_wr && tgt.addr == `DMAS_SFR_PCL;
      if (sfr_wr && tgt.addr == `DMAS_SFR_PCL) begin
        pcl_reg     <= wr_byte;
        pc_jump_low <= wr_byte;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_have_reg;
      if (state_reg == dmas_pkg::ST_WEXEC) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      w_have_reg   <= 1'b0;
      w_data_reg   <= `DMAS_ZERO_BYTE;
      w_en_reg     <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata[7:0];
      w_en_reg     <= s_axi_wstrb[0];
    end else begin
      s_axi_wready <= s_axi_wvalid && !w_have_reg;
      if (state_reg == dmas_pkg::ST_WEXEC) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transaction sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg     <= dmas_pkg::ST_IDLE;
      s_axi_arready <= 1'b0;
      ar_addr_reg   <= 12'h000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DMAS_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DMAS_RESP_OKAY;
      prog_req      <= 1'b0;
      prog_addr     <= 16'h0000;
      tbl_dest_reg  <= `DMAS_ZERO_BYTE;
    end else begin
      unique case (state_reg)
        dmas_pkg::ST_IDLE: begin
          if (aw_have_reg && w_have_reg) begin
            state_reg <= dmas_pkg::ST_WEXEC;
          end else if (s_axi_arvalid) begin
            ar_addr_reg   <= s_axi_araddr;
            s_axi_arready <= 1'b1;
            state_reg     <= dmas_pkg::ST_REXEC;
          end
        end
        dmas_pkg::ST_WEXEC: begin
          s_axi_bresp <= `DMAS_RESP_OKAY;
          if (aw_addr_reg == `DMAS_AXI_TBLRD) begin
            tbl_dest_reg <= w_data_reg;
            prog_addr    <= {HAS_TABLE_POINTER_HIGH ? table_pointer_high_reg : `DMAS_ZERO_BYTE, table_pointer_low_reg};
            prog_req     <= 1'b1;
            state_reg    <= dmas_pkg::ST_TBL1;
          end else if (!cur_is_data) begin
            s_axi_bresp  <= `DMAS_RESP_SLVERR;
            s_axi_bvalid <= 1'b1;
            state_reg    <= dmas_pkg::ST_BRESP;
          end else if (sfr_wr && tgt.addr == `DMAS_SFR_PCL) begin
            state_reg <= dmas_pkg::ST_WDUMMY;
          end else begin
            s_axi_bvalid <= 1'b1;
            state_reg    <= dmas_pkg::ST_BRESP;
          end
        end
        dmas_pkg::ST_TBL1: begin
          prog_req  <= 1'b0;
          state_reg <= dmas_pkg::ST_TBL2;
        end
        dmas_pkg::ST_TBL2: begin
          if (sfr_wr && tgt.addr == `DMAS_SFR_PCL) begin
            state_reg <= dmas_pkg::ST_WDUMMY;
          end else begin
            s_axi_bvalid <= 1'b1;
            state_reg    <= dmas_pkg::ST_BRESP;
          end
        end
        dmas_pkg::ST_WDUMMY: begin
          s_axi_bvalid <= 1'b1;
          state_reg    <= dmas_pkg::ST_BRESP;
        end
        dmas_pkg::ST_BRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            state_reg    <= dmas_pkg::ST_IDLE;
          end
        end
        dmas_pkg::ST_REXEC: begin
          s_axi_arready <= 1'b0;
          s_axi_rvalid  <= 1'b1;
          s_axi_rdata   <= {24'h000000, cur_is_data ? rd_byte : `DMAS_ZERO_BYTE};
          s_axi_rresp   <= cur_is_data ? `DMAS_RESP_OKAY : `DMAS_RESP_SLVERR;
          state_reg     <= dmas_pkg::ST_RRESP;
        end
        dmas_pkg::ST_RRESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            state_reg    <= dmas_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  assign acc_out = acc_reg;

endmodule : dmas_sfr_core

`default_nettype wire

//--- hw/dmas_regs.svh
`ifndef DMAS_REGS_SVH
`define DMAS_REGS_SVH

// ----------------------------------------------------------------------------
// Special function register addresses in data memory
// ----------------------------------------------------------------------------
`define DMAS_SFR_IND_FIRST    8'h00
`define DMAS_SFR_PTR_FIRST    8'h01
`define DMAS_SFR_IND_SECOND   8'h02
`define DMAS_SFR_PTR_SECOND   8'h03
`define DMAS_SFR_BANK_SEL     8'h04
`define DMAS_SFR_ACC          8'h05
`define DMAS_SFR_PCL          8'h06
`define DMAS_SFR_TABLE_POINTER_LOW         8'h07
`define DMAS_SFR_TABLE_HIGH_BYTE_LATCH         8'h08
`define DMAS_SFR_TABLE_POINTER_HIGH         8'h09

// ----------------------------------------------------------------------------
// Field positions and fixed values
// ----------------------------------------------------------------------------
`define DMAS_GEN_BIT          7
`define DMAS_BANK0            2'h0
`define DMAS_ZERO_BYTE        8'h00
`define DMAS_PORT_READ        8'h00

// ----------------------------------------------------------------------------
// AXI4-Lite map: data address n sits at byte 4*n, table read command above
// ----------------------------------------------------------------------------
`define DMAS_AXI_TBLRD        12'h400
`define DMAS_RESP_OKAY        2'h0
`define DMAS_RESP_SLVERR      2'h2

`endif

//--- hw/dmas_pkg.sv
`default_nettype none

package dmas_pkg;

  // --------------------------------------------------------------------------
  // Bus slave states
  // --------------------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_WEXEC  = 8'h02,
    ST_WDUMMY = 8'h04,
    ST_BRESP  = 8'h08,
    ST_REXEC  = 8'h10,
    ST_RRESP  = 8'h20,
    ST_TBL1   = 8'h40,
    ST_TBL2   = 8'h80
  } dmas_state_t;

  // --------------------------------------------------------------------------
  // Resolved data memory target of one access
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       nop;
    logic       ram;
    logic [1:0] bank;
    logic [7:0] addr;
  } dmas_target_t;

endpackage : dmas_pkg

`default_nettype wire

//--- hw/dmas_bank_sel.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmas_regs.svh"

module dmas_bank_sel #(
  parameter int NUM_BANKS = 4
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       wdt_idle_rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  // Selection
  output logic      [1:0] bank,
  output logic      [7:0] rdata
);

  logic [1:0] bank_reg;
  logic [1:0] bank_next;

  always_comb begin
    bank_next = bank_reg;
    if (wr_en) begin
      if (NUM_BANKS == 4) begin
        bank_next = wdata[1:0];
      end else if (NUM_BANKS == 2) begin
        bank_next = {1'b0, wdata[0]};
      end
    end
  end

  // A watchdog reset out of idle or sleep keeps the selection.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      if (!wdt_idle_rst) begin
        bank_reg <= `DMAS_BANK0;
      end
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign bank  = bank_reg;
  assign rdata = {6'h00, bank_reg};

endmodule : dmas_bank_sel

`default_nettype wire

//--- hw/dmas_data_ram.sv
`timescale 1ns/10ps
`default_nettype none

module dmas_data_ram #(
  parameter int NUM_BANKS = 4
) (
  // Clock
  input  wire logic       sys_clk,
  // Access
  input  wire logic       wr_en,
  input  wire logic [1:0] bank,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  localparam int AW = $clog2(NUM_BANKS * 128);

  logic [7:0]    mem [NUM_BANKS * 128];
  logic [AW-1:0] index;

  // Bank bits sit above the 7-bit offset within the general region.
  assign index = AW'({bank, addr});

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[index] <= wdata;
    end
  end

  assign rdata = mem[index];

endmodule : dmas_data_ram

`default_nettype wire

//--- sim/dmas_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmas_regs.svh"

module dmas_monitor #(
  parameter int NUM_BANKS = 4
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Core side
  input wire logic        alu_valid,
  input wire logic [7:0]  alu_result,
  input wire logic [7:0]  acc_out,
  input wire logic        prog_req,
  input wire logic [15:0] prog_addr,
  input wire logic        pc_jump,
  input wire logic [7:0]  pc_jump_low
);
  logic [31:0] w_cap;
  logic [11:0] ar_cap;
  logic [2:0]  quiet;

  always_ff @(posedge sys_clk) begin
    if (s_axi_wvalid && s_axi_wready) w_cap <= s_axi_wdata;
  end

  always_ff @(posedge sys_clk) begin
    if (s_axi_arvalid && s_axi_arready) ar_cap <= s_axi_araddr;
  end

  // Counts idle cycles so that no bus write can still land in the accumulator.
  always_ff @(posedge sys_clk) begin
    if (rst || s_axi_awvalid || s_axi_wvalid || s_axi_bvalid || prog_req) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_pcl_dummy_cycle: assert property (pc_jump |-> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("jump write response not one cycle late");
  a_pcl_jump_value: assert property (pc_jump && !$past(prog_req, 2) |-> pc_jump_low == w_cap[7:0])
    else $error("jump low byte differs from written value");
  a_table_fetch_pulse: assert property (prog_req |=> !prog_req && $stable(prog_addr))
    else $error("table fetch request not a single pulse");
  a_table_fetch_done: assert property (prog_req |-> ##[2:4] s_axi_bvalid)
    else $error("table read response missing");
  a_bank_sel_bits: assert property (s_axi_rvalid && ar_cap == 12'h010 && s_axi_rresp == 2'h0 |->
    (NUM_BANKS == 4 ? s_axi_rdata[31:2] == 30'h0 : s_axi_rdata[31:1] == 31'h0))
    else $error("unused bank selector bits not zero");
  a_error_data_zero: assert property (s_axi_rvalid && s_axi_rresp == `DMAS_RESP_SLVERR |->
    s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_acc_alu_load: assert property (alu_valid && quiet >= 3'h4 |=> acc_out == $past(alu_result))
    else $error("accumulator missed an ALU result");
endmodule : dmas_monitor

bind dmas_sfr_core dmas_monitor #(.NUM_BANKS(NUM_BANKS)) u_mon (.sys_clk(sys_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .alu_valid(alu_valid),
  .alu_result(alu_result), .acc_out(acc_out), .prog_req(prog_req), .prog_addr(prog_addr),
  .pc_jump(pc_jump), .pc_jump_low(pc_jump_low));

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmas_regs.svh"

module testbench;
  localparam logic [1:0] OK = `DMAS_RESP_OKAY;
  localparam logic [1:0] ER = `DMAS_RESP_SLVERR;
  logic sys_clk, rst, wdt_idle_rst, alu_valid, prog_req, pc_jump;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  alu_result, acc_out, pc_jump_low, jump_val;
  logic [15:0] prog_addr, prog_rdata;
  int          num_errors, n_checks, cyc, jumps;

  dmas_sfr_core #(.NUM_BANKS(4)) uut (.sys_clk(sys_clk), .rst(rst), .wdt_idle_rst(wdt_idle_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .alu_valid(alu_valid),
    .alu_result(alu_result), .acc_out(acc_out), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .pc_jump(pc_jump), .pc_jump_low(pc_jump_low));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Program memory answers the cycle after a fetch and toggles otherwise.
  always @(posedge sys_clk) begin
    prog_rdata <= prog_req ? {prog_addr[7:0] ^ 8'ha5, prog_addr[15:8] ^ 8'h3c} : ~prog_rdata;
    if (pc_jump === 1'b1) begin
      jumps <= jumps + 1;
      jump_val <= pc_jump_low;
    end
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  task end_sim;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [11:0] ad(input logic [7:0] n);
    return {2'b00, n, 2'b00};
  endfunction : ad

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  task rst_cycle(input logic wdt);
    rst <= 1'b1;
    wdt_idle_rst <= wdt;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    wdt_idle_rst <= 1'b0;
  endtask : rst_cycle

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {wdt_idle_rst, alu_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {alu_result, prog_rdata, num_errors, n_checks, cyc, jumps, jump_val} = '0;
    s_axi_wstrb = 4'h1;
    rst_cycle(1'b0);
    rd(ad(8'h04), 8'h00, OK);
    rd(ad(8'h01), 8'h00, OK);
    wr(ad(8'h01), 8'h80, OK);
    wr(ad(8'h04), 8'hff, OK);
    rd(ad(8'h04), 8'h03, OK);
    wr(ad(8'h00), 8'h5a, OK);
    rd(ad(8'h80), 8'h5a, OK);
    wr(ad(8'h03), 8'h80, OK);
    wr(ad(8'h02), 8'h33, OK);
    rd(ad(8'h80), 8'h5a, OK);
    rd(ad(8'h00), 8'h5a, OK);
    rd(ad(8'h02), 8'h33, OK);
    wr(ad(8'h04), 8'h00, OK);
    rd(ad(8'h02), 8'h5a, OK);
    wr(ad(8'h04), 8'h02, OK);
    wr(ad(8'h02), 8'h66, OK);
    rd(ad(8'h03), 8'h80, OK);
    wr(ad(8'h04), 8'h03, OK);
    rd(ad(8'h02), 8'h33, OK);
    wr(ad(8'h03), 8'h05, OK);
    wr(ad(8'h02), 8'h77, OK);
    rd(ad(8'h05), 8'h77, OK);
    wr(ad(8'h01), 8'h00, OK);
    wr(ad(8'h00), 8'h11, OK);
    rd(ad(8'h00), 8'h00, OK);
    wr(ad(8'h01), 8'h02, OK);
    rd(ad(8'h00), 8'h00, OK);
    repeat (5) @(posedge sys_clk);
    alu_valid <= 1'b1;
    alu_result <= 8'h3c;
    @(posedge sys_clk);
    alu_valid <= 1'b0;
    rd(ad(8'h05), 8'h3c, OK);
    wr(ad(8'h06), 8'h12, OK);
    chk(jumps, 1);
    chk({24'h0, jump_val}, 32'h12);
    wr(ad(8'h07), 8'h34, OK);
    wr(ad(8'h09), 8'h12, OK);
    wr(`DMAS_AXI_TBLRD, 8'h81, OK);
    rd(ad(8'h08), 8'h91, OK);
    rd(ad(8'h81), 8'h2e, OK);
    rd(12'h401, 8'h00, ER);
    wr(12'h011, 8'h01, ER);
    wr(ad(8'h04), 8'h02, OK);
    rst_cycle(1'b1);
    rd(ad(8'h04), 8'h02, OK);
    rst_cycle(1'b0);
    rd(ad(8'h04), 8'h00, OK);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
